// *** logic/smcm_pkg.sv ***
package smcm_pkg;

  // Widths
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 24;

  // Register offsets (byte addresses on the plain register port)
  localparam logic [15:0] OFS_MEAS_COUNT      = 16'h048C;
  localparam logic [15:0] OFS_PERIOD_CAPTURE  = 16'h048F;
  localparam logic [15:0] OFS_WIDTH_CAPTURE   = 16'h0492;
  localparam logic [15:0] OFS_PERIOD_LIMIT    = 16'h0495;
  localparam logic [15:0] OFS_CONTROL_A       = 16'h0498;
  localparam logic [15:0] OFS_CONTROL_B       = 16'h0499;
  localparam logic [15:0] OFS_STATUS          = 16'h049A;
  localparam logic [15:0] OFS_CLOCK_SELECT    = 16'h049B;
  localparam logic [15:0] OFS_SIGNAL_SELECT   = 16'h049C;
  localparam logic [15:0] OFS_WINDOW_SELECT   = 16'h049D;
  localparam logic [15:0] OFS_IRQ_STATUS      = 16'h049E;
  localparam logic [15:0] OFS_IRQ_ENABLE      = 16'h049F;

  // Control A fields
  localparam int unsigned CA_ENABLE = 7;
  localparam int unsigned CA_HALT   = 5;
  localparam int unsigned CA_WPOL   = 4;
  localparam int unsigned CA_SPOL   = 3;

  // Control B fields
  localparam int unsigned CB_RUN    = 7;
  localparam int unsigned CB_REPEAT = 6;
  localparam int unsigned CB_MODE_L = 0;
  localparam int unsigned MODE_W    = 4;

  // Status fields
  localparam int unsigned ST_PFORCE = 7;
  localparam int unsigned ST_WFORCE = 6;
  localparam int unsigned ST_CLEAR  = 4;
  localparam int unsigned ST_RUNNING = 2;
  localparam int unsigned ST_WLEVEL = 1;
  localparam int unsigned ST_SLEVEL = 0;

  // Interrupt status and enable bit positions
  localparam int unsigned IRQ_WIDTH  = 0;
  localparam int unsigned IRQ_PERIOD = 1;
  localparam int unsigned IRQ_MATCH  = 2;
  localparam int unsigned IRQ_N      = 3;

  // Counter mode encodings
  localparam logic [3:0] MODE_FREE     = 4'h8;
  localparam logic [3:0] MODE_GATED    = 4'h9;
  localparam logic [3:0] MODE_WINDOWED = 4'hA;

  // Reset values
  localparam logic [23:0] COUNT_RST = 24'h00_0000;
  localparam logic [23:0] LIMIT_RST = 24'hFF_FFFF;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [2:0]  IRQ_RST   = 3'h0;

  // Sequencer states
  typedef enum logic [1:0] {
    SMCM_IDLE,
    SMCM_WAIT,
    SMCM_COUNT
  } smcm_state_e;

  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } smcm_req_s;

endpackage

// *** logic/smcm_counter.sv ***
`timescale 1ns/100ps
// Overview of operation
// R1: Free mode counts each signal pulse
// R2: Free mode: window fall captures width
// R3: Gated mode starts at window rise
// R4: Gated mode: window fall captures width
// R5: Windowed mode: start at rise, capture at fall
// R6: Windowed mode: later rises capture period
// R7: Width capture raises width flag
// R8: Period capture raises period flag
// R9: Count equal limit raises match flag
// R10: Each flag has its own enable
// R11: Keeps measuring while its sources run
// R12: 24-bit count, byte views, resets zero
// R13: Period capture read-only, not reset
// R14: Width capture read-only, not reset
// R15: Single acquisition stops and clears run
// R16: Halt bit holds count at limit
// R17: Force bits copy count into captures
// R18: Clear bit zeroes the count
// R19: Window edges aligned with signal sampling
module smcm_counter (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  // Register port
  input  wire smcm_pkg::smcm_req_s bus_req,
  output logic [7:0]              rd_data_r,
  // Measured inputs
  input  wire logic               sig_pin,
  input  wire logic               win_pin,
  // Interrupt
  output logic                    irq_r
);

  // Byte lane update of a 24-bit register
  function automatic logic [23:0] put_byte(input logic [23:0] val, input logic [1:0] idx, input logic [7:0] b);
    logic [23:0] res;
    res = val;
    case (idx)
      2'h0:    res[7:0]   = b;
      2'h1:    res[15:8]  = b;
      default: res[23:16] = b;
    endcase
    return res;
  endfunction

  // Address falls within a three byte register
  function automatic logic in_triple(input logic [15:0] addr, input logic [15:0] base);
    return (addr >= base) && (addr < base + 16'h0003);
  endfunction

  // Byte of a 24-bit register
  function automatic logic [7:0] get_byte(input logic [23:0] val, input logic [1:0] idx);
    case (idx)
      2'h0:    return val[7:0];
      2'h1:    return val[15:8];
      default: return val[23:16];
    endcase
  endfunction

  // Registers
  logic [23:0]              cnt_r;
  logic [23:0]              cpr_r;
  logic [23:0]              cpw_r;
  logic [23:0]              limit_r;
  logic [7:0]               con_a_r;
  logic [7:0]               con_b_r;
  logic [7:0]               clk_sel_r;
  logic [7:0]               sig_sel_r;
  logic [7:0]               win_sel_r;
  logic [2:0]               irq_st_r;
  logic [2:0]               irq_en_r;
  smcm_pkg::smcm_state_e    state_r;
  smcm_pkg::smcm_state_e    state_nxt;
  logic                     sig_s1_r;
  logic                     sig_s2_r;
  logic                     sig_s3_r;
  logic                     win_s1_r;
  logic                     win_s2_r;
  logic                     win_s3_r;
  logic [7:0]               rd_nxt;

  // Bus decode
  wire        wr          = bus_req.wr;
  wire [15:0] addr        = bus_req.addr;
  wire [7:0]  wdata       = bus_req.wdata;
  wire        wr_cnt      = wr && in_triple(addr, smcm_pkg::OFS_MEAS_COUNT);
  wire        wr_limit    = wr && in_triple(addr, smcm_pkg::OFS_PERIOD_LIMIT);
  wire        wr_stat     = wr && (addr == smcm_pkg::OFS_STATUS);
  wire [1:0]  cnt_idx     = 2'(addr - smcm_pkg::OFS_MEAS_COUNT);
  wire [1:0]  limit_idx   = 2'(addr - smcm_pkg::OFS_PERIOD_LIMIT);
  wire        clr_req     = wr_stat && wdata[smcm_pkg::ST_CLEAR];
  wire        wforce      = wr_stat && wdata[smcm_pkg::ST_WFORCE];
  wire        pforce      = wr_stat && wdata[smcm_pkg::ST_PFORCE];
  wire        sw_cnt      = wr_cnt || clr_req;

  // Control fields
  wire        enable      = con_a_r[smcm_pkg::CA_ENABLE];
  wire        halt        = con_a_r[smcm_pkg::CA_HALT];
  wire        run         = con_b_r[smcm_pkg::CB_RUN];
  wire        repeat_on   = con_b_r[smcm_pkg::CB_REPEAT];
  wire [3:0]  mode        = con_b_r[smcm_pkg::CB_MODE_L +: smcm_pkg::MODE_W];
  wire        m_free      = (mode == smcm_pkg::MODE_FREE);
  wire        m_gated     = (mode == smcm_pkg::MODE_GATED);
  wire        m_windowed  = (mode == smcm_pkg::MODE_WINDOWED);
  wire        m_counter   = m_free || m_gated || m_windowed;

  // Polarity-corrected levels and edges, both inputs sampled together
  wire        sig_now     = sig_s2_r ^ con_a_r[smcm_pkg::CA_SPOL];
  wire        sig_prev    = sig_s3_r ^ con_a_r[smcm_pkg::CA_SPOL];
  wire        win_now     = win_s2_r ^ con_a_r[smcm_pkg::CA_WPOL];
  wire        win_prev    = win_s3_r ^ con_a_r[smcm_pkg::CA_WPOL];
  wire        sig_rise    = sig_now && !sig_prev;
  wire        win_rise    = win_now && !win_prev;  // R19
  wire        win_fall    = !win_now && win_prev;  // R19

  // Measurement events
  wire        counting    = (state_r == smcm_pkg::SMCM_COUNT);
  wire        inc         = counting && sig_rise && (!m_gated || win_now);  // R1 R3
  wire        at_limit    = (cnt_r == limit_r);
  wire        match       = inc && at_limit;  // R9
  wire        hw_wcap     = counting && win_fall;  // R2 R4 R5
  wire        hw_pcap     = counting && m_windowed && win_rise;  // R6
  wire        wcap        = hw_wcap || wforce;  // R17
  wire        pcap        = hw_pcap || pforce;  // R17
  wire        acq_done    = m_windowed ? hw_pcap : hw_wcap;
  wire        single_done = acq_done && !repeat_on;  // R15
  wire [23:0] cnt_inc     = at_limit ? (halt ? cnt_r : smcm_pkg::COUNT_RST) : cnt_r + 24'h00_0001;  // R16
  wire [2:0]  irq_set     = {match, pcap, wcap};  // R7 R8 R9
  wire        irq_nxt     = |(irq_st_r & irq_en_r);  // R10

  // Input synchronisers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sig_s1_r <= 1'b0;
      sig_s2_r <= 1'b0;
      sig_s3_r <= 1'b0;
      win_s1_r <= 1'b0;
      win_s2_r <= 1'b0;
      win_s3_r <= 1'b0;
    end else begin
      sig_s1_r <= sig_pin;
      sig_s2_r <= sig_s1_r;
      sig_s3_r <= sig_s2_r;
      win_s1_r <= win_pin;
      win_s2_r <= win_s1_r;
      win_s3_r <= win_s2_r;
    end
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    if (!enable || !run || !m_counter) begin
      state_nxt = smcm_pkg::SMCM_IDLE;
    end else begin
      case (state_r)
        smcm_pkg::SMCM_IDLE:  state_nxt = m_free ? smcm_pkg::SMCM_COUNT : smcm_pkg::SMCM_WAIT;
        smcm_pkg::SMCM_WAIT:  state_nxt = win_rise ? smcm_pkg::SMCM_COUNT : smcm_pkg::SMCM_WAIT;  // R3 R5
        smcm_pkg::SMCM_COUNT: begin
          if (single_done) begin
            state_nxt = smcm_pkg::SMCM_IDLE;  // R15
          end else if (m_gated && hw_wcap) begin
            state_nxt = smcm_pkg::SMCM_WAIT;
          end
        end
        default: state_nxt = smcm_pkg::SMCM_IDLE;
      endcase
    end
  end

  // Sequencer state; runs on core_clk, the only clock of the counter
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= smcm_pkg::SMCM_IDLE;
    end else begin
      state_r <= state_nxt;  // R11
    end
  end

  // Count register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= smcm_pkg::COUNT_RST;  // R12
    end else if (clr_req) begin
      cnt_r <= smcm_pkg::COUNT_RST;  // R18
    end else if (wr_cnt) begin
      cnt_r <= put_byte(cnt_r, cnt_idx, wdata);  // R12
    end else if (hw_pcap) begin
      cnt_r <= inc ? 24'h00_0001 : smcm_pkg::COUNT_RST;
    end else if (inc) begin
      cnt_r <= cnt_inc;  // R1 R16
    end
  end

  // Capture registers, no reset: contents undefined until first capture
  always_ff @(posedge core_clk) begin
    if (wcap) begin
      cpw_r <= cnt_r;  // R2 R4 R14
    end
    if (pcap) begin
      cpr_r <= cnt_r;  // R6 R13
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      limit_r   <= smcm_pkg::LIMIT_RST;
      con_a_r   <= smcm_pkg::BYTE_RST;
      clk_sel_r <= smcm_pkg::BYTE_RST;
      sig_sel_r <= smcm_pkg::BYTE_RST;
      win_sel_r <= smcm_pkg::BYTE_RST;
      irq_en_r  <= smcm_pkg::IRQ_RST;
    end else if (wr) begin
      if (wr_limit) begin
        limit_r <= put_byte(limit_r, limit_idx, wdata);
      end
      if (addr == smcm_pkg::OFS_CONTROL_A) begin
        con_a_r <= wdata;
      end
      if (addr == smcm_pkg::OFS_CLOCK_SELECT) begin
        clk_sel_r <= wdata;
      end
      if (addr == smcm_pkg::OFS_SIGNAL_SELECT) begin
        sig_sel_r <= wdata;
      end
      if (addr == smcm_pkg::OFS_WINDOW_SELECT) begin
        win_sel_r <= wdata;
      end
      if (addr == smcm_pkg::OFS_IRQ_ENABLE) begin
        irq_en_r <= wdata[2:0];  // R10
      end
    end
  end

  // Control B; a finished single acquisition drops the run bit
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      con_b_r <= smcm_pkg::BYTE_RST;
    end else if (wr && (addr == smcm_pkg::OFS_CONTROL_B)) begin
      con_b_r <= wdata;
    end else if (single_done) begin
      con_b_r[smcm_pkg::CB_RUN] <= 1'b0;  // R15
    end
  end

  // Sticky flags, write one to clear, set wins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_st_r <= smcm_pkg::IRQ_RST;
    end else if (wr && (addr == smcm_pkg::OFS_IRQ_STATUS)) begin
      irq_st_r <= (irq_st_r & ~wdata[2:0]) | irq_set;  // R7 R8 R9
    end else begin
      irq_st_r <= irq_st_r | irq_set;  // R7 R8 R9
    end
  end

  // Read mux
  always_comb begin
    rd_nxt = smcm_pkg::BYTE_RST;
    if (in_triple(addr, smcm_pkg::OFS_MEAS_COUNT)) begin
      rd_nxt = get_byte(cnt_r, cnt_idx);
    end else if (in_triple(addr, smcm_pkg::OFS_PERIOD_CAPTURE)) begin
      rd_nxt = get_byte(cpr_r, 2'(addr - smcm_pkg::OFS_PERIOD_CAPTURE));
    end else if (in_triple(addr, smcm_pkg::OFS_WIDTH_CAPTURE)) begin
      rd_nxt = get_byte(cpw_r, 2'(addr - smcm_pkg::OFS_WIDTH_CAPTURE));
    end else if (in_triple(addr, smcm_pkg::OFS_PERIOD_LIMIT)) begin
      rd_nxt = get_byte(limit_r, limit_idx);
    end else begin
      case (addr)
        smcm_pkg::OFS_CONTROL_A:     rd_nxt = con_a_r;
        smcm_pkg::OFS_CONTROL_B:     rd_nxt = con_b_r;
        smcm_pkg::OFS_STATUS:        rd_nxt = {5'h00, counting, win_now, sig_now};
        smcm_pkg::OFS_CLOCK_SELECT:  rd_nxt = clk_sel_r;
        smcm_pkg::OFS_SIGNAL_SELECT: rd_nxt = sig_sel_r;
        smcm_pkg::OFS_WINDOW_SELECT: rd_nxt = win_sel_r;
        smcm_pkg::OFS_IRQ_STATUS:    rd_nxt = {5'h00, irq_st_r};
        smcm_pkg::OFS_IRQ_ENABLE:    rd_nxt = {5'h00, irq_en_r};
        default:                     rd_nxt = smcm_pkg::BYTE_RST;
      endcase
    end
  end

  // Output flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= smcm_pkg::BYTE_RST;
      irq_r     <= 1'b0;
    end else begin
      rd_data_r <= bus_req.rd ? rd_nxt : smcm_pkg::BYTE_RST;
      irq_r     <= irq_nxt;  // R10
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_free_pulse;
    counting && m_free && sig_rise && !sw_cnt && !at_limit;
  endsequence

  sequence s_window_close;
    counting && win_fall && !wforce;
  endsequence

  sequence s_waiting_quiet;
    state_r == smcm_pkg::SMCM_WAIT && !win_rise && !sw_cnt;
  endsequence

  chk_free_count_step: assert property (s_free_pulse |=> cnt_r == $past(cnt_r) + 24'h00_0001)  // R1
    else $error("free count did not step");
  chk_free_width_cap: assert property (s_window_close and m_free |=> cpw_r == $past(cnt_r))  // R2
    else $error("free mode width capture wrong");
  chk_gated_wait_hold: assert property (s_waiting_quiet and m_gated |=> cnt_r == $past(cnt_r))  // R3
    else $error("gated count moved before window rise");
  chk_gated_width_cap: assert property (s_window_close and m_gated |=> cpw_r == $past(cnt_r))  // R4
    else $error("gated width capture wrong");
  chk_window_start: assert property (
      state_r == smcm_pkg::SMCM_WAIT && win_rise && enable && run && m_windowed
      |=> state_r == smcm_pkg::SMCM_COUNT)  // R5
    else $error("windowed count did not start");
  chk_window_period_cap: assert property (counting && m_windowed && win_rise && !pforce
      |=> cpr_r == $past(cnt_r) ##0 irq_st_r[smcm_pkg::IRQ_PERIOD])  // R6
    else $error("windowed period capture wrong");
  chk_width_flag_set: assert property (wcap |=> irq_st_r[smcm_pkg::IRQ_WIDTH])  // R7
    else $error("width flag not raised");
  chk_period_flag_set: assert property (pcap |=> irq_st_r[smcm_pkg::IRQ_PERIOD])  // R8
    else $error("period flag not raised");
  chk_match_flag_set: assert property (inc && cnt_r == limit_r |=> irq_st_r[smcm_pkg::IRQ_MATCH])  // R9
    else $error("match flag not raised");
  chk_irq_mask_gate: assert property (##1 irq_r == $past(irq_nxt))  // R10
    else $error("interrupt output disagrees with mask");
  chk_single_stop_run: assert property (single_done && !(wr && addr == smcm_pkg::OFS_CONTROL_B)
      |=> !run ##1 state_r == smcm_pkg::SMCM_IDLE)  // R15
    else $error("single acquisition did not stop");
  chk_halt_hold_limit: assert property (match && halt && !sw_cnt && !hw_pcap |=> cnt_r == $past(limit_r))  // R16
    else $error("halt did not hold count at limit");
  chk_wrap_to_zero: assert property (match && !halt && !sw_cnt && !hw_pcap |=> cnt_r == smcm_pkg::COUNT_RST)  // R16
    else $error("count did not wrap to zero");
  chk_force_capture: assert property (wforce |=> cpw_r == $past(cnt_r))  // R17
    else $error("forced width capture wrong");
  chk_force_period_cap: assert property (pforce |=> cpr_r == $past(cnt_r))  // R17
    else $error("forced period capture wrong");
  chk_clear_count: assert property (clr_req |=> cnt_r == smcm_pkg::COUNT_RST)  // R18
    else $error("clear did not zero count");

  // Idle, software access and flag bookkeeping
  sequence s_idle_quiet;
    state_r == smcm_pkg::SMCM_IDLE && !sw_cnt;
  endsequence

  sequence s_period_flag_wipe;
    wr && addr == smcm_pkg::OFS_IRQ_STATUS && wdata[smcm_pkg::IRQ_PERIOD] && !pcap;
  endsequence

  sequence s_gate_opens;
    state_r == smcm_pkg::SMCM_WAIT && win_rise && enable && run && m_gated;
  endsequence

  chk_idle_no_count: assert property (s_idle_quiet |=> cnt_r == $past(cnt_r))  // R15
    else $error("count moved while idle");
  chk_count_low_write: assert property (wr_cnt && cnt_idx == 2'h0 && !clr_req |=> cnt_r[7:0] == $past(wdata))  // R12
    else $error("count low byte write lost");
  chk_limit_low_write: assert property (wr_limit && limit_idx == 2'h0 |=> limit_r[7:0] == $past(wdata))  // R9
    else $error("limit low byte write lost");
  chk_window_restart: assert property (hw_pcap && !sw_cnt |=> cnt_r <= 24'h00_0001)  // R6
    else $error("windowed count did not restart");
  chk_period_flag_clear: assert property (s_period_flag_wipe |=> !irq_st_r[smcm_pkg::IRQ_PERIOD])  // R8
    else $error("period flag not cleared");
  chk_width_flag_sticky: assert property (irq_st_r[smcm_pkg::IRQ_WIDTH] && !wr |=> irq_st_r[smcm_pkg::IRQ_WIDTH])  // R7
    else $error("width flag dropped on its own");
  chk_gated_start: assert property (s_gate_opens |=> counting)  // R3
    else $error("gated count did not start");

endmodule

// *** sim/smcm_src_model.sv ***
`timescale 1ns/100ps
// Signal and window sources at the far side of the counter
module smcm_src_model (
  // Clock that only paces the edges
  input  wire logic core_clk,
  // Measured inputs
  output logic      sig_pin,
  output logic      win_pin
);
  localparam int unsigned HOLD = 4; // Clocks per level, above the two-flop minimum

  // Quiet lines at time zero
  initial begin
    sig_pin = 1'b0;
    win_pin = 1'b0;
  end

  // Wait a number of clock edges
  task automatic hold_cycles(input int unsigned n);
    repeat (n) @(posedge core_clk);
  endtask

  // Burst of signal pulses, each level held long enough to be seen
  task automatic pulses(input int unsigned n);
    repeat (n) begin
      @(posedge core_clk);
      sig_pin <= 1'b1;
      hold_cycles(HOLD);
      sig_pin <= 1'b0;
      hold_cycles(HOLD);
    end
  endtask

  // Window level change, then time for detection and flag update
  task automatic window(input logic lvl);
    @(posedge core_clk);
    win_pin <= lvl;
    hold_cycles(2 * HOLD);
  endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/100ps
// Self-checking bench for the counter modes
module tb;
  logic                core_clk;
  logic                rst_b;
  smcm_pkg::smcm_req_s bus_req;
  logic [7:0]          rd_data_r;
  logic                sig_pin;
  logic                win_pin;
  logic                irq_r;
  int                  fail_count;
  int                  cmp_count;
  logic [23:0]         val;
  logic [7:0]          b;

  smcm_counter dut (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data_r(rd_data_r),
                    .sig_pin(sig_pin), .win_pin(win_pin), .irq_r(irq_r));
  smcm_src_model src (.core_clk(core_clk), .sig_pin(sig_pin), .win_pin(win_pin));

  // Free-running clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Compare and count
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One strobe for one cycle beside address and data, then both strobes low
  task automatic xfer(input logic [15:0] a, input logic [7:0] d, input logic w);
    @(posedge core_clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= w;
    bus_req.rd    <= !w;
    @(posedge core_clk);
    {bus_req.wr, bus_req.rd} <= 2'b00;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    xfer(a, d, 1'b1);
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    xfer(a, bus_req.wdata, 1'b0);
    #1 d = rd_data_r;
  endtask

  // Three-byte accesses, low byte first
  task automatic rd24(input logic [15:0] a, output logic [23:0] v);
    logic [7:0] t;
    for (int i = 0; i < 3; i++) begin
      rd(a + 16'(i), t);
      v[8*i +: 8] = t;
    end
  endtask

  task automatic wr24(input logic [15:0] a, input logic [23:0] v);
    for (int i = 0; i < 3; i++) wr(a + 16'(i), v[8*i +: 8]);
  endtask

  // Bounded wait for the interrupt level
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq_r !== lvl && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (irq_r !== lvl) begin
      fail_count++;
      $display("[FAIL] %0t interrupt wait ran out", $time);
      end_sim();
    end
  endtask

  // Values after reset and an unmapped read
  task automatic test_reset();
    rd24(smcm_pkg::OFS_MEAS_COUNT, val);
    check(val, smcm_pkg::COUNT_RST);
    rd24(smcm_pkg::OFS_PERIOD_LIMIT, val);
    check(val, 24'hFF_FFFF);
    @(posedge core_clk);
    #1 check({16'h0000, rd_data_r}, 24'h00_0000);
    rd(smcm_pkg::OFS_IRQ_STATUS, b);
    check({16'h0000, b}, 24'h00_0000);
    rd(16'h0400, b);
    check({16'h0000, b}, 24'h00_0000);
    check({23'h00_0000, irq_r}, 24'h00_0000);
  endtask

  // Byte views of the count and the clear bit
  task automatic test_count_rw();
    wr24(smcm_pkg::OFS_MEAS_COUNT, 24'h56_3412);
    rd24(smcm_pkg::OFS_MEAS_COUNT, val);
    check(val, 24'h56_3412);
    wr(smcm_pkg::OFS_STATUS, 8'h10);
    rd24(smcm_pkg::OFS_MEAS_COUNT, val);
    check(val, 24'h00_0000);
  endtask

  // Free counting, width capture, flag, mask and clear
  task automatic test_free();
    wr(smcm_pkg::OFS_IRQ_ENABLE, 8'h01);
    wr(smcm_pkg::OFS_CONTROL_A, 8'h80);
    wr(smcm_pkg::OFS_CONTROL_B, {2'b11, 2'b00, smcm_pkg::MODE_FREE});
    src.window(1'b1);
    src.pulses(5);
    rd24(smcm_pkg::OFS_MEAS_COUNT, val);
    check(val, 24'h00_0005);
    src.window(1'b0);
    rd24(smcm_pkg::OFS_WIDTH_CAPTURE, val);
    check(val, 24'h00_0005);
    rd(smcm_pkg::OFS_IRQ_STATUS, b);
    check({16'h0000, b}, 24'h00_0001);
    wait_irq(1'b1);
    check({23'h00_0000, irq_r}, 24'h00_0001);
    wr(smcm_pkg::OFS_WIDTH_CAPTURE, 8'hAA);
    rd(smcm_pkg::OFS_WIDTH_CAPTURE, b);
    check({16'h0000, b}, 24'h00_0005);
    wr(smcm_pkg::OFS_IRQ_ENABLE, 8'h00);
    wait_irq(1'b0);
    check({23'h00_0000, irq_r}, 24'h00_0000);
    wr(smcm_pkg::OFS_IRQ_STATUS, 8'h01);
    rd(smcm_pkg::OFS_IRQ_STATUS, b);
    check({16'h0000, b}, 24'h00_0000);
    wr(smcm_pkg::OFS_CONTROL_B, 8'h00);
  endtask

  // Gated single acquisition
  task automatic test_gated();
    wr(smcm_pkg::OFS_STATUS, 8'h10);
    wr(smcm_pkg::OFS_CONTROL_B, {2'b10, 2'b00, smcm_pkg::MODE_GATED});
    src.pulses(2);
    rd24(smcm_pkg::OFS_MEAS_COUNT, val);
    check(val, 24'h00_0000);
    src.window(1'b1);
    src.pulses(3);
    src.window(1'b0);
    rd24(smcm_pkg::OFS_WIDTH_CAPTURE, val);
    check(val, 24'h00_0003);
    rd(smcm_pkg::OFS_CONTROL_B, b);
    check({16'h0000, b}, {16'h0000, 4'h0, smcm_pkg::MODE_GATED});
    src.pulses(2);
    rd24(smcm_pkg::OFS_MEAS_COUNT, val);
    check(val, 24'h00_0003);
  endtask

  // Windowed repeat: no period capture on the first rise
  task automatic test_windowed();
    wr(smcm_pkg::OFS_STATUS, 8'h10);
    wr(smcm_pkg::OFS_IRQ_STATUS, 8'h07);
    wr(smcm_pkg::OFS_CONTROL_B, {2'b11, 2'b00, smcm_pkg::MODE_WINDOWED});
    src.window(1'b1);
    rd(smcm_pkg::OFS_IRQ_STATUS, b);
    check({16'h0000, b}, 24'h00_0000);
    rd(smcm_pkg::OFS_STATUS, b);
    check({16'h0000, b}, 24'h00_0006);
    src.pulses(2);
    src.window(1'b0);
    rd24(smcm_pkg::OFS_WIDTH_CAPTURE, val);
    check(val, 24'h00_0002);
    src.window(1'b1);
    rd24(smcm_pkg::OFS_PERIOD_CAPTURE, val);
    check(val, 24'h00_0002);
    rd(smcm_pkg::OFS_IRQ_STATUS, b);
    check({16'h0000, b}, 24'h00_0003);
    rd24(smcm_pkg::OFS_MEAS_COUNT, val);
    check(val, 24'h00_0000);
    wr(smcm_pkg::OFS_CONTROL_B, 8'h00);
    src.window(1'b0);
  endtask

  // Match with and without halt
  task automatic test_match();
    for (int h = 0; h < 2; h++) begin
      wr24(smcm_pkg::OFS_PERIOD_LIMIT, 24'h00_0003);
      wr(smcm_pkg::OFS_STATUS, 8'h10);
      wr(smcm_pkg::OFS_IRQ_STATUS, 8'h07);
      wr(smcm_pkg::OFS_CONTROL_A, (h == 1) ? 8'hA0 : 8'h80);
      wr(smcm_pkg::OFS_CONTROL_B, {2'b11, 2'b00, smcm_pkg::MODE_FREE});
      src.pulses(4);
      rd24(smcm_pkg::OFS_MEAS_COUNT, val);
      check(val, (h == 1) ? 24'h00_0003 : 24'h00_0000);
      rd(smcm_pkg::OFS_IRQ_STATUS, b);
      check({16'h0000, b}, 24'h00_0004);
      wr(smcm_pkg::OFS_CONTROL_B, 8'h00);
    end
  endtask

  // Software force into both captures
  task automatic test_force();
    wr24(smcm_pkg::OFS_MEAS_COUNT, 24'hAB_CDEF);
    wr(smcm_pkg::OFS_IRQ_STATUS, 8'h07);
    wr(smcm_pkg::OFS_STATUS, 8'h40);
    rd24(smcm_pkg::OFS_WIDTH_CAPTURE, val);
    check(val, 24'hAB_CDEF);
    wr(smcm_pkg::OFS_STATUS, 8'h80);
    rd24(smcm_pkg::OFS_PERIOD_CAPTURE, val);
    check(val, 24'hAB_CDEF);
    rd(smcm_pkg::OFS_IRQ_STATUS, b);
    check({16'h0000, b}, 24'h00_0003);
  endtask

  // Reset in mid-run: count cleared, captures kept
  task automatic test_warm_reset();
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd24(smcm_pkg::OFS_MEAS_COUNT, val);
    check(val, smcm_pkg::COUNT_RST);
    rd24(smcm_pkg::OFS_PERIOD_CAPTURE, val);
    check(val, 24'hAB_CDEF);
    rd24(smcm_pkg::OFS_WIDTH_CAPTURE, val);
    check(val, 24'hAB_CDEF);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    bus_req = '0;
    rst_b = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    test_reset();
    test_count_rw();
    test_free();
    test_gated();
    test_windowed();
    test_match();
    test_force();
    test_warm_reset();
    end_sim();
  end
endmodule
